// ### src/sadc_core.sv
// What this block does
// RULE1 - Convert selected input to 12 bits, MSB first
// RULE2 - Channel code 0-11 inputs, 15 supply
// RULE3 - Ten set-up plus four per bit: 58
// RULE4 - Completion loads result, sets flag, interrupt
// RULE5 - Done flag reads zero while converting
// RULE6 - Done flag cleared when disabled or stopped
// RULE7 - Runs only enabled and not in stop
// RULE8 - Writing one to start triggers conversion
// RULE9 - Three-bit field picks the trigger source
// RULE10 - Alignment bit chooses left or right result
// RULE11 - Conversion clock is core divided 1/2/4/8
// RULE12 - Interrupt flag cleared by zero or acknowledge
// RULE13 - Software keeps conversion at least 20 us
// RULE14 - Triggers ignored while disabled or busy
// RULE15 - Unused result bits read as zero
//
// ADC sequencer top: APB slave, trigger select, clock divider, result registers.
// Assumes timer events and int_ack are core-clock pulses; cmp_out is asynchronous.
`timescale 1ns/1ps
`include "sadc_defines.svh"

module sadc_core (
	input wire logic core_clk, // Core clock, 200 MHz
	input wire logic rstn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic stop_mode, // CPU in stop mode
	input wire logic tmr3_match_a, // Timer 3 A-match pulse
	input wire logic tmr4_match_a, // Timer 4 A-match pulse
	input wire logic tmr5_match_a, // Timer 5 A-match pulse
	input wire logic tmr8_ovf, // Timer 8 overflow pulse
	input wire logic tmr8_match_a, // Timer 8 A-match pulse
	input wire logic tmr8_match_b, // Timer 8 B-match pulse
	input wire logic tmr8_match_c, // Timer 8 C-match pulse
	input wire logic int_ack, // Interrupt controller acknowledge
	input wire logic cmp_out, // Comparator, input above DAC
	output logic [11:0] ain_sel, // One-hot external input switch
	output logic core_supply_sel, // Internal supply channel switch
	output logic converter_on, // Analog core powered
	output logic sample_hold, // Sampling during set-up
	output logic [11:0] dac_code, // Trial code to DAC
	output logic adc_irq // Level interrupt
);

	// ********************************
	// Helpers
	// ********************************
	function automatic logic [2:0] div_last(input logic [1:0] sel);
		begin
			div_last = 3'(({2'b00, 1'b1} << sel) - 3'h1);
		end
	endfunction : div_last

	function automatic logic [12:0] chan_decode(input logic [3:0] code);
		logic [12:0] r;
		begin
			r = 13'h0000;
			if (code <= `SADC_CHAN_LAST)
			begin
				r[code] = 1'b1;
			end
			else if (code == `SADC_CHAN_SUPPLY)
			begin
				r[12] = 1'b1;
			end
			chan_decode = r;
		end
	endfunction : chan_decode

	// ********************************
	// Registers and wires
	// ********************************
	logic en_q;
	logic [3:0] chan_q;
	logic [2:0] trigger_source_select_q;
	logic align_q;
	logic [1:0] clkdiv_q;
	logic done_flag_q;
	logic irqf_q;
	logic [7:0] res_hi_q;
	logic [7:0] res_lo_q;
	logic [1:0] stat_q;
	logic [1:0] mask_q;
	logic [31:0] prdata_q;
	logic [1:0] stat_rd_q;
	logic [2:0] div_q;
	logic cmp_meta_q;
	logic cmp_sync_q;
	logic [12:0] chan_q_dec;
	logic [11:0] ain_q;
	logic supply_q;
	logic [9:0] idx;
	logic setup_ph;
	logic access_ph;
	logic wr_acc;
	logic hit;
	logic active;
	logic sw_start;
	logic trigger_source_select_pulse;
	logic start_ok;
	logic start_drop;
	logic busy;
	logic done;
	logic tick;
	logic [11:0] result;

	assign idx = paddr[11:2];
	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign wr_acc = access_ph & pwrite;
	assign hit = (idx == `SADC_IDX_RES_LO) | (idx == `SADC_IDX_RES_HI)
		| (idx == `SADC_IDX_CTRL_LO) | (idx == `SADC_IDX_CTRL_HI)
		| (idx == `SADC_IDX_IRQ_STAT) | (idx == `SADC_IDX_IRQ_MASK);
	assign pready = 1'b1;
	assign pslverr = access_ph & ~hit;
	assign prdata = prdata_q;

	// RULE7 enable gated by stop
	assign active = en_q & ~stop_mode;
	assign converter_on = active;

	// RULE8 only a written one starts
	assign sw_start = wr_acc & (idx == `SADC_IDX_CTRL_LO) & pwdata[`SADC_LO_START_BIT];

	// RULE9 trigger source select
	always_comb
	begin
		case (sadc_pkg::sadc_trigger_source_select_t'(trigger_source_select_q))
			sadc_pkg::SADC_TRG_SW: trigger_source_select_pulse = sw_start;
			sadc_pkg::SADC_TRG_T3A: trigger_source_select_pulse = tmr3_match_a;
			sadc_pkg::SADC_TRG_T4A: trigger_source_select_pulse = tmr4_match_a;
			sadc_pkg::SADC_TRG_T5A: trigger_source_select_pulse = tmr5_match_a;
			sadc_pkg::SADC_TRG_T8OVF: trigger_source_select_pulse = tmr8_ovf;
			sadc_pkg::SADC_TRG_T8A: trigger_source_select_pulse = tmr8_match_a;
			sadc_pkg::SADC_TRG_T8B: trigger_source_select_pulse = tmr8_match_b;
			sadc_pkg::SADC_TRG_T8C: trigger_source_select_pulse = tmr8_match_c;
			default: trigger_source_select_pulse = 1'b0;
		endcase
	end

	// RULE14 drop triggers when off or busy
	assign start_ok = trigger_source_select_pulse & active & ~busy;
	assign start_drop = trigger_source_select_pulse & ~start_ok;

	// ********************************
	// Comparator synchroniser
	// ********************************
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmp_meta_q <= 1'b0;
			cmp_sync_q <= 1'b0;
		end
		else
		begin
			cmp_meta_q <= cmp_out;
			cmp_sync_q <= cmp_meta_q;
		end
	end

	// ********************************
	// Conversion clock divider
	// ********************************
	// RULE11 divide by 1, 2, 4 or 8
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_q <= 3'h0;
		end
		else if (!busy || div_q == div_last(clkdiv_q))
		begin
			div_q <= 3'h0;
		end
		else
		begin
			div_q <= div_q + 3'h1;
		end
	end

	assign tick = busy & (div_q == div_last(clkdiv_q));

	sadc_sar u_sar (
		.clk(core_clk),
		.rstn(rstn),
		.tick(tick),
		.start(start_ok),
		.abort(~active),
		.cmp_hi(cmp_sync_q),
		.busy(busy),
		.done(done),
		.sample(sample_hold),
		.trial(result)
	);

	assign dac_code = result;

	// ********************************
	// Input multiplexer select
	// ********************************
	assign chan_q_dec = chan_decode(chan_q);

	// RULE2 one-hot channel routing
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ain_q <= 12'h000;
			supply_q <= 1'b0;
		end
		else
		begin
			ain_q <= active ? chan_q_dec[11:0] : 12'h000;
			supply_q <= active & chan_q_dec[12];
		end
	end

	assign ain_sel = ain_q;
	assign core_supply_sel = supply_q;

	// ********************************
	// Control registers
	// ********************************
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			en_q <= 1'(`SADC_CTRL_LO_RST >> `SADC_LO_EN_BIT);
			chan_q <= 4'(`SADC_CTRL_LO_RST);
			trigger_source_select_q <= 3'(`SADC_CTRL_HI_RST >> 3);
			align_q <= 1'b0;
			clkdiv_q <= 2'h0;
			mask_q <= `SADC_MASK_RST;
		end
		else if (wr_acc)
		begin
			if (idx == `SADC_IDX_CTRL_LO)
			begin
				en_q <= pwdata[`SADC_LO_EN_BIT];
				chan_q <= pwdata[3:0];
			end
			if (idx == `SADC_IDX_CTRL_HI)
			begin
				trigger_source_select_q <= pwdata[5:3];
				align_q <= pwdata[`SADC_HI_ALIGN_BIT];
				clkdiv_q <= pwdata[1:0];
			end
			if (idx == `SADC_IDX_IRQ_MASK)
			begin
				mask_q <= pwdata[1:0];
			end
		end
	end

	// ********************************
	// Completion flag and result
	// ********************************
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			done_flag_q <= 1'b0;
		end
		// RULE6 forced clear when off
		else if (!active)
		begin
			done_flag_q <= 1'b0;
		end
		// RULE4 completion sets flag
		else if (done)
		begin
			done_flag_q <= 1'b1;
		end
		// RULE5 flag low during conversion
		else if (start_ok)
		begin
			done_flag_q <= 1'b0;
		end
	end

	// Aligned once at load, so later align writes leave results intact
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			res_hi_q <= `SADC_RES_RST;
			res_lo_q <= `SADC_RES_RST;
		end
		// RULE4 result load
		else if (done)
		begin
			// RULE10 left or right placement
			// RULE15 unused bits zero
			if (align_q)
			begin
				res_hi_q <= {4'h0, result[11:8]};
				res_lo_q <= result[7:0];
			end
			else
			begin
				res_hi_q <= result[11:4];
				res_lo_q <= {result[3:0], 4'h0};
			end
		end
	end

	// ********************************
	// Interrupt flag and sticky status
	// ********************************
	// RULE12 set wins over write-zero or acknowledge
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			irqf_q <= 1'b0;
		end
		else if (done)
		begin
			irqf_q <= 1'b1;
		end
		else if (int_ack || (wr_acc && idx == `SADC_IDX_CTRL_HI && !pwdata[`SADC_HI_IRQF_BIT]))
		begin
			irqf_q <= 1'b0;
		end
	end

	// Only bits captured in the setup cycle are cleared, so nothing set later is lost
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stat_q <= 2'h0;
		end
		else
		begin
			stat_q <= (stat_q & ~((access_ph && !pwrite && idx == `SADC_IDX_IRQ_STAT)
				? stat_rd_q : 2'h0)) | {start_drop, done};
		end
	end

	assign adc_irq = |(stat_q & mask_q);

	// ********************************
	// APB read data, captured in the setup cycle
	// ********************************
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prdata_q <= 32'h0000_0000;
			stat_rd_q <= 2'h0;
		end
		else if (setup_ph && !pwrite)
		begin
			stat_rd_q <= (idx == `SADC_IDX_IRQ_STAT) ? stat_q : 2'h0;
			case (idx)
				`SADC_IDX_RES_LO: prdata_q <= {24'h000000, res_lo_q};
				`SADC_IDX_RES_HI: prdata_q <= {24'h000000, res_hi_q};
				// RULE5 flag masked while busy
				`SADC_IDX_CTRL_LO: prdata_q <= {24'h000000, en_q, 2'b00,
					done_flag_q & ~busy, chan_q};
				`SADC_IDX_CTRL_HI: prdata_q <= {24'h000000, 1'b0, irqf_q, trigger_source_select_q,
					align_q, clkdiv_q};
				`SADC_IDX_IRQ_STAT: prdata_q <= {30'h00000000, stat_q};
				`SADC_IDX_IRQ_MASK: prdata_q <= {30'h00000000, mask_q};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

endmodule : sadc_core

// ### src/sadc_defines.svh
// Offsets, field positions, reset values and timing counts of the ADC sequencer.
// Assumes APB byte addresses equal four times the register index.
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH

// ********************************
// Register indices (byte address = 4 * index)
// ********************************
`define SADC_IDX_RES_LO 10'h0E2
`define SADC_IDX_RES_HI 10'h0E3
`define SADC_IDX_CTRL_LO 10'h0EA
`define SADC_IDX_CTRL_HI 10'h0EB
`define SADC_IDX_IRQ_STAT 10'h0F0
`define SADC_IDX_IRQ_MASK 10'h0F1

// ********************************
// Field positions
// ********************************
`define SADC_LO_EN_BIT 7
`define SADC_LO_START_BIT 6
`define SADC_LO_DONE_BIT 4
`define SADC_HI_IRQF_BIT 6
`define SADC_HI_ALIGN_BIT 2
`define SADC_ST_DONE_BIT 0
`define SADC_ST_DROP_BIT 1

// ********************************
// Reset values
// ********************************
`define SADC_CTRL_LO_RST 8'h00
`define SADC_CTRL_HI_RST 8'h00
`define SADC_RES_RST 8'h00
`define SADC_MASK_RST 2'h0

// ********************************
// Channel codes
// ********************************
`define SADC_CHAN_LAST 4'hB
`define SADC_CHAN_SUPPLY 4'hF

// ********************************
// Timing, in conversion-clock cycles unless noted
// ********************************
`define SADC_SETUP_CYCLES 4'hA
`define SADC_CYCLES_PER_BIT 4'h4
`define SADC_RESULT_BITS 4'hC
`define SADC_TOTAL_CYCLES 58
`define SADC_CORE_CLK_PERIOD_NS 5
`define SADC_MIN_CONV_NS 20000
`define SADC_MIN_CONV_CORE_CYC ((`SADC_MIN_CONV_NS + `SADC_CORE_CLK_PERIOD_NS - 1) / `SADC_CORE_CLK_PERIOD_NS)

`endif

// ### src/sadc_pkg.sv
// Types shared by the ADC sequencer modules.
// Assumes the defines header supplies the register and timing numbers; the state and trigger codes are set here.
package sadc_pkg;

	// ********************************
	// Approximation engine states
	// ********************************
	typedef enum logic [1:0] {
		SADC_IDLE = 2'b00,
		SADC_SETUP = 2'b01,
		SADC_BITS = 2'b10
	} sadc_state_t;

	// ********************************
	// Trigger sources
	// ********************************
	typedef enum logic [2:0] {
		SADC_TRG_SW = 3'b000,
		SADC_TRG_T3A = 3'b001,
		SADC_TRG_T4A = 3'b010,
		SADC_TRG_T5A = 3'b011,
		SADC_TRG_T8OVF = 3'b100,
		SADC_TRG_T8A = 3'b101,
		SADC_TRG_T8B = 3'b110,
		SADC_TRG_T8C = 3'b111
	} sadc_trigger_source_select_t;

endpackage : sadc_pkg

// ### src/sadc_sar.sv
// Successive-approximation engine: set-up phase, then one bit per step, MSB first.
// Assumes tick is a one-cycle conversion-clock enable and cmp_hi is already synchronised.
`timescale 1ns/1ps
`include "sadc_defines.svh"

module sadc_sar (
	input wire logic clk, // Core clock
	input wire logic rstn, // Async reset, active low
	input wire logic tick, // Conversion clock enable
	input wire logic start, // Begin a conversion
	input wire logic abort, // Drop the conversion at once
	input wire logic cmp_hi, // Input above trial level
	output logic busy, // Conversion under way
	output logic done, // One-cycle completion pulse
	output logic sample, // Sample/hold during set-up
	output logic [11:0] trial // Trial code to the DAC
);

	sadc_pkg::sadc_state_t state_q;
	logic [3:0] cnt_q;
	logic [3:0] bit_q;
	logic [11:0] trial_q;
	logic done_q;

	assign busy = (state_q != sadc_pkg::SADC_IDLE);
	assign done = done_q;
	assign sample = (state_q == sadc_pkg::SADC_SETUP);
	assign trial = trial_q;

	// ********************************
	// Sequencer
	// ********************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= sadc_pkg::SADC_IDLE;
			cnt_q <= 4'h0;
			bit_q <= 4'h0;
			trial_q <= 12'h000;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (abort)
			begin
				state_q <= sadc_pkg::SADC_IDLE;
			end
			else
			begin
				case (state_q)
					sadc_pkg::SADC_IDLE:
					begin
						if (start)
						begin
							state_q <= sadc_pkg::SADC_SETUP;
							cnt_q <= 4'h0;
						end
					end
					// RULE3 set-up count
					sadc_pkg::SADC_SETUP:
					begin
						if (tick)
						begin
							if (cnt_q == `SADC_SETUP_CYCLES - 4'h1)
							begin
								state_q <= sadc_pkg::SADC_BITS;
								cnt_q <= 4'h0;
								bit_q <= `SADC_RESULT_BITS - 4'h1;
								trial_q <= 12'h800;
							end
							else
							begin
								cnt_q <= cnt_q + 4'h1;
							end
						end
					end
					// RULE1 MSB-first decisions
					sadc_pkg::SADC_BITS:
					begin
						if (tick)
						begin
							// RULE3 four cycles per bit
							if (cnt_q == `SADC_CYCLES_PER_BIT - 4'h1)
							begin
								cnt_q <= 4'h0;
								trial_q[bit_q] <= cmp_hi;
								if (bit_q == 4'h0)
								begin
									state_q <= sadc_pkg::SADC_IDLE;
									done_q <= 1'b1;
								end
								else
								begin
									trial_q[bit_q - 4'h1] <= 1'b1;
									bit_q <= bit_q - 4'h1;
								end
							end
							else
							begin
								cnt_q <= cnt_q + 4'h1;
							end
						end
					end
					default:
					begin
						state_q <= sadc_pkg::SADC_IDLE;
					end
				endcase
			end
		end
	end

endmodule : sadc_sar

// ### tb/sadc_analog_model.sv
// Stand-in for the analog input switch and comparator.
// Assumes the bench gives one level per channel, the supply level last.
`timescale 1ns/1ps

module sadc_analog_model (
	input wire logic [11:0] ain_sel, // Input switch
	input wire logic core_supply_sel, // Supply switch
	input wire logic [11:0] dac_code, // Trial code
	input wire logic [12:0][11:0] level, // Channel levels
	output logic cmp_out // Input at or above trial
);
	logic [11:0] v;

	always_comb
	begin
		v = level[12];
		for (int i = 0; i < 12; i++)
			if (ain_sel[i])
				v = level[i];
	end

	// ideal comparator settles at once, so short conversions suffice
	// Nothing switched in: a toggling pattern, not a settled level
	assign cmp_out = (ain_sel == 12'h000 && !core_supply_sel) ? ^dac_code : (v >= dac_code);
endmodule : sadc_analog_model

// ### tb/sadc_core_bench.sv
// Self-checking bench of the ADC sequencer over APB.
// Assumes the analog model closes the comparator loop.
`timescale 1ns/1ps
`include "sadc_defines.svh"
`define CHK(a, b) cmp_count++; if ((a) !== (b)) begin fail_count++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end

module sadc_core_bench;
	logic core_clk, rstn, psel, penable, pwrite, stop_mode, int_ack, pready, pslverr, cmp_out;
	logic adc_irq, core_supply_sel, converter_on, sample_hold;
	logic [11:0] paddr, ain_sel, dac_code;
	logic [31:0] pwdata, prdata;
	logic [6:0] tmr;
	logic [12:0][11:0] level;
	int fail_count = 0;
	int cmp_count = 0;
	int cyc = 0;

	sadc_core u_sadc_core (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stop_mode(stop_mode), .tmr3_match_a(tmr[0]), .tmr4_match_a(tmr[1]),
		.tmr5_match_a(tmr[2]), .tmr8_ovf(tmr[3]), .tmr8_match_a(tmr[4]), .tmr8_match_b(tmr[5]),
		.tmr8_match_c(tmr[6]), .int_ack(int_ack), .cmp_out(cmp_out), .ain_sel(ain_sel),
		.core_supply_sel(core_supply_sel), .converter_on(converter_on),
		.sample_hold(sample_hold), .dac_code(dac_code), .adc_irq(adc_irq));
	sadc_analog_model u_sadc_analog_model (.ain_sel(ain_sel), .core_supply_sel(core_supply_sel),
		.dac_code(dac_code), .level(level), .cmp_out(cmp_out));

	always #2.5 core_clk = ~core_clk;

	// *******
	// Helpers
	// *******
	task automatic complete_run();
		$display("Mismatches %0d, comparisons %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			complete_run();
		end
	end

	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd,
		output logic [31:0] r, output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, idx, d, r, e);
	endtask : wr

	task automatic rd_chk(input logic [9:0] idx, input logic [7:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, idx, 8'h00, r, e);
		`CHK(r, {24'h000000, x})
		`CHK(e, 1'b0)
	endtask : rd_chk

	task automatic wait_irq(input int lim, output int n);
		n = 0;
		while (adc_irq !== 1'b1 && n < lim)
		begin
			@(negedge core_clk);
			n++;
		end
	endtask : wait_irq

	// *********
	// Scenarios
	// *********
	task automatic t_regs();
		logic [31:0] r;
		logic e;
		wr(`SADC_IDX_RES_LO, 8'hFF);
		rd_chk(`SADC_IDX_RES_LO, 8'h00);
		rd_chk(`SADC_IDX_RES_HI, 8'h00);
		rd_chk(`SADC_IDX_CTRL_LO, 8'h00);
		rd_chk(`SADC_IDX_CTRL_HI, 8'h00);
		rd_chk(`SADC_IDX_IRQ_MASK, 8'h00);
		apb(1'b0, 10'h010, 8'h00, r, e);
		`CHK({e, r}, 33'h100000000)
	endtask : t_regs

	task automatic t_convert(input int i);
		logic [3:0] ch;
		logic [11:0] v;
		int n;
		int d;
		ch = 4'(i * 5);
		d = 1 << i;
		v = (ch == 4'hF) ? level[12] : level[ch];
		wr(`SADC_IDX_CTRL_HI, {5'h00, i[0], i[1:0]});
		wr(`SADC_IDX_CTRL_LO, {4'h8, ch});
		wr(`SADC_IDX_CTRL_LO, {4'hC, ch});
		rd_chk(`SADC_IDX_CTRL_LO, {4'h8, ch});
		`CHK({core_supply_sel, ain_sel}, (ch == 4'hF) ? 13'h1000 : 13'(1 << ch))
		wait_irq(600, n);
		`CHK(n >= 56 * d && n <= 59 * d + 2, 1'b1)
		rd_chk(`SADC_IDX_CTRL_LO, {4'h9, ch});
		rd_chk(`SADC_IDX_RES_HI, i[0] ? {4'h0, v[11:8]} : v[11:4]);
		rd_chk(`SADC_IDX_RES_LO, i[0] ? v[7:0] : {v[3:0], 4'h0});
		rd_chk(`SADC_IDX_CTRL_HI, {2'b01, 3'b000, i[0], i[1:0]});
		rd_chk(`SADC_IDX_IRQ_STAT, 8'h01);
		@(negedge core_clk);
		`CHK(adc_irq, 1'b0)
	endtask : t_convert

	task automatic t_triggers();
		int n;
		wr(`SADC_IDX_CTRL_LO, 8'h8C);
		repeat (2) @(negedge core_clk);
		`CHK({core_supply_sel, ain_sel}, 13'h0000)
		wr(`SADC_IDX_CTRL_LO, 8'h80);
		for (int c = 1; c < 8; c++)
		begin
			wr(`SADC_IDX_CTRL_HI, {2'b00, 3'(c), 3'b000});
			// Unselected events first: a wrong start would drop the real one
			@(posedge core_clk);
			tmr <= ~(7'h01 << (c - 1));
			@(posedge core_clk);
			tmr <= 7'h01 << (c - 1);
			@(posedge core_clk);
			tmr <= 7'h00;
			wait_irq(70, n);
			`CHK(n < 64, 1'b1)
			rd_chk(`SADC_IDX_IRQ_STAT, 8'h01);
		end
	endtask : t_triggers

	task automatic t_abort();
		int n;
		wr(`SADC_IDX_CTRL_HI, 8'h00);
		wr(`SADC_IDX_CTRL_LO, 8'hC0);
		@(posedge core_clk);
		stop_mode <= 1'b1;
		@(negedge core_clk);
		`CHK(converter_on, 1'b0)
		wr(`SADC_IDX_CTRL_LO, 8'hC0);
		@(posedge core_clk);
		stop_mode <= 1'b0;
		wait_irq(80, n);
		`CHK(n, 80)
		rd_chk(`SADC_IDX_IRQ_STAT, 8'h02);
		wr(`SADC_IDX_CTRL_LO, 8'hC0);
		// Second start lands mid-conversion and must be dropped
		wr(`SADC_IDX_CTRL_LO, 8'hC0);
		wait_irq(80, n);
		wr(`SADC_IDX_CTRL_LO, 8'h00);
		rd_chk(`SADC_IDX_CTRL_LO, 8'h00);
		rd_chk(`SADC_IDX_IRQ_STAT, 8'h03);
		wr(`SADC_IDX_CTRL_LO, 8'h40);
		wait_irq(80, n);
		rd_chk(`SADC_IDX_IRQ_STAT, 8'h02);
	endtask : t_abort

	task automatic t_irqflag();
		int n;
		wr(`SADC_IDX_CTRL_HI, 8'h00);
		rd_chk(`SADC_IDX_CTRL_HI, 8'h00);
		wr(`SADC_IDX_CTRL_HI, 8'h40);
		rd_chk(`SADC_IDX_CTRL_HI, 8'h00);
		// Masked completion: flag and status set, line stays low
		wr(`SADC_IDX_IRQ_MASK, 8'h00);
		wr(`SADC_IDX_CTRL_LO, 8'h80);
		wr(`SADC_IDX_CTRL_LO, 8'hC0);
		wait_irq(80, n);
		`CHK(n, 80)
		rd_chk(`SADC_IDX_CTRL_HI, 8'h40);
		rd_chk(`SADC_IDX_CTRL_LO, 8'h90);
		stop_mode <= 1'b1;
		rd_chk(`SADC_IDX_CTRL_LO, 8'h80);
		stop_mode <= 1'b0;
		@(posedge core_clk);
		int_ack <= 1'b1;
		@(posedge core_clk);
		int_ack <= 1'b0;
		rd_chk(`SADC_IDX_CTRL_HI, 8'h00);
		rd_chk(`SADC_IDX_IRQ_STAT, 8'h01);
	endtask : t_irqflag

	initial
	begin
		core_clk = 1'b0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		stop_mode = 1'b0;
		int_ack = 1'b0;
		tmr = 7'h00;
		level = {13{12'h7FF}};
		level[0] = 12'hFFF;
		level[5] = 12'h000;
		level[10] = 12'hA5C;
		level[12] = 12'h5A3;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		t_regs();
		wr(`SADC_IDX_IRQ_MASK, 8'h01);
		for (int i = 0; i < 4; i++)
			t_convert(i);
		t_triggers();
		t_abort();
		t_irqflag();
		complete_run();
	end
endmodule : sadc_core_bench

// ### tb/sadc_core_checker.sv
// Port-level properties of the ADC sequencer top.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
`include "sadc_defines.svh"

module sadc_core_checker (
	input wire logic core_clk, // Clock
	input wire logic rstn, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic [11:0] paddr, // Address
	input wire logic pslverr, // Error
	input wire logic stop_mode, // Stop
	input wire logic [11:0] ain_sel, // Input switch
	input wire logic core_supply_sel, // Supply switch
	input wire logic converter_on, // Powered
	input wire logic sample_hold, // Sampling
	input wire logic [11:0] dac_code // Trial code
);
	// *******
	// Helpers
	// *******
	logic [6:0] hold_q;
	logic mapped;

	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	assign mapped = paddr[11:2] inside {`SADC_IDX_RES_LO, `SADC_IDX_RES_HI, `SADC_IDX_CTRL_LO,
		`SADC_IDX_CTRL_HI, `SADC_IDX_IRQ_STAT, `SADC_IDX_IRQ_MASK};

	// Saturates so a stuck sampling window cannot wrap into range
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			hold_q <= 7'h00;
		else if (!sample_hold)
			hold_q <= 7'h00;
		else if (hold_q != 7'h7F)
			hold_q <= hold_q + 7'h01;
	end

	// **********
	// Properties
	// **********
	a_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
		else $error("slave error does not match address map");
	a_stop_off: assert property (stop_mode |-> !converter_on)
		else $error("converter on during stop");
	a_idle_sel: assert property (!converter_on |=> ain_sel == 12'h000 && !core_supply_sel)
		else $error("input switched while converter off");
	a_abort_sample: assert property (!converter_on [*2] |-> !sample_hold)
		else $error("sampling while converter off");
	a_one_hot: assert property ($onehot0({ain_sel, core_supply_sel}))
		else $error("more than one input switched in");
	a_setup_len: assert property ($fell(sample_hold) && converter_on |->
		hold_q >= 7'h09 && hold_q <= 7'h50)
		else $error("set-up window length wrong");
	a_first_trial: assert property ($fell(sample_hold) && converter_on |-> dac_code == 12'h800)
		else $error("first trial is not the top bit");
	a_trial_hold: assert property ($fell(sample_hold) && converter_on |=> $stable(dac_code) [*3])
		else $error("trial code changed before four steps");
endmodule : sadc_core_checker

bind sadc_core sadc_core_checker u_sadc_core_checker (.core_clk(core_clk), .rstn(rstn),
	.psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr), .stop_mode(stop_mode),
	.ain_sel(ain_sel), .core_supply_sel(core_supply_sel), .converter_on(converter_on),
	.sample_hold(sample_hold), .dac_code(dac_code));
